// >>> dvs_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef DVS_MAP_SVH
`define DVS_MAP_SVH

//------------------------------------------------------------
// timing
//------------------------------------------------------------
`define DVS_CLK_HZ          10000000
`define DVS_DEAD_NS         30
`define DVS_DEAD_CYC        (((`DVS_DEAD_NS * (`DVS_CLK_HZ / 1000000)) + 999) / 1000)
`define DVS_SYNC_LOSS_US    20
`define DVS_SYNC_LOSS_CYC   (`DVS_SYNC_LOSS_US * (`DVS_CLK_HZ / 1000000))
`define DVS_STEP_CYC        4'hF
`define DVS_DAC_TOP         7'h40
`define DVS_DAC_ZERO        7'h00

//------------------------------------------------------------
// register map
//------------------------------------------------------------
`define DVS_OFS_CTRL        4'h0
`define DVS_OFS_STATUS      4'h4
`define DVS_CTRL_EN_BIT     0
`define DVS_CTRL_INT_BIT    1
`define DVS_CTRL_RESET      2'h1

`endif

// >>> dvs_pkg.sv
// types shared by the sequencer
`default_nettype none
package dvs_pkg;
  // ramp sequencer states
  typedef enum logic [1:0] {
    DVS_OFF,
    DVS_RAMP_UP,
    DVS_ON,
    DVS_RAMP_DOWN
  } dvs_state_t;

  // clock-output mode picked from the sync pin
  typedef enum logic [1:0] {
    DVS_CK_INPHASE,
    DVS_CK_QUAD,
    DVS_CK_SLAVE
  } dvs_ckmode_t;

  // gate pair of one channel
  typedef struct packed {
    logic hs;
    logic ls;
  } dvs_gate_t;

  // readable status word
  typedef struct packed {
    logic       supply_low_lockout;
    logic       hot;
    logic       pgood;
    logic       ext_sync;
    logic       ramp_done;
    dvs_state_t state;
    logic [6:0] dac;
  } dvs_status_t;
endpackage
`default_nettype wire

// >>> dvs_sequencer.sv
// dual regulator sequencer: soft ramp, power-good, clock modes, gate drive
`include "dvs_map.svh"
`default_nettype none

module dvs_sequencer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // pins
  input  wire logic        i_enable,
  input  wire logic        i_sync,
  input  wire logic        i_osc,
  input  wire logic [1:0]  i_under90,
  input  wire logic        i_thermal,
  input  wire logic        i_supply_low_lockout,
  input  wire logic [1:0]  i_pwm_end,
  output var  dvs_pkg::dvs_gate_t [1:0] o_gate,
  output logic             o_high_side_to_switch_node,
  output logic             o_comp_discharge,
  output logic [6:0]       o_dac_code,
  output logic             o_ramp_done,
  output logic             o_phase_clock_out,
  output logic             o_power_good_rst_n_out,
  output logic             o_power_good_rst_n_oe,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);

  //----------------------------------------------------------
  // declarations
  //----------------------------------------------------------
  logic [1:0]  ctrl_reg;          // sw enable, force internal osc
  logic        ack_reg;           // bus answer phase
  logic [31:0] rdata_reg;         // read data, valid with ack
  logic [1:0]  und_s1_reg;        // first synchroniser stage
  logic [1:0]  und_reg;           // synchronised under-90% flags
  logic        hot_s1_reg;
  logic        hot_reg;
  logic        osc_d_reg;         // previous oscillator sample
  logic        sync_d_reg;        // previous sync sample
  logic [7:0]  loss_cnt_reg;      // cycles since last sync edge
  logic        ext_reg;           // external sync is live
  logic        sw_clk_reg;        // divided switching clock
  logic        ck_reg;            // phase clock output
  logic        cyc1_reg;          // channel 1 cycle start pulse
  logic        cyc2_reg;          // channel 2 cycle start pulse
  logic [3:0]  step_cnt_reg;      // switching cycles per dac step
  logic [6:0]  dac_reg;
  logic        en_d_reg;
  logic        pg_reg;            // power good, released when high
  dvs_pkg::dvs_state_t  state_reg;
  dvs_pkg::dvs_ckmode_t mode;
  logic        fault;
  logic        enable;
  logic        osc_rise;
  logic        sync_rise;
  logic        src_rise;
  logic        run;
  logic        req;
  logic        sel_ctrl;
  logic        sel_stat;
  dvs_pkg::dvs_status_t status;

  //----------------------------------------------------------
  // input conditioning
  //----------------------------------------------------------
  // two flops on the analog comparators and thermal sensor
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      und_s1_reg <= 2'h0;
      und_reg    <= 2'h0;
      hot_s1_reg <= 1'h0;
      hot_reg    <= 1'h0;
    end else begin
      und_s1_reg <= i_under90;
      und_reg    <= und_s1_reg;
      hot_s1_reg <= i_thermal;
      hot_reg    <= hot_s1_reg;
    end
  end

  // lockout acts straight away; it is a reset-like condition
  assign fault  = hot_reg | i_supply_low_lockout;
  assign enable = i_enable & ctrl_reg[`DVS_CTRL_EN_BIT];

  //----------------------------------------------------------
  // clock source selection
  //----------------------------------------------------------
  assign osc_rise  = i_osc & ~osc_d_reg;
  assign sync_rise = i_sync & ~sync_d_reg;

  // edge history for oscillator and sync pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_d_reg  <= 1'h0;
      sync_d_reg <= 1'h0;
    end else begin
      osc_d_reg  <= i_osc;
      sync_d_reg <= i_sync;
    end
  end

  // sync watchdog: no rising edge for a while means the clock is gone
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      loss_cnt_reg <= 8'h00;
      ext_reg      <= 1'h0;
    end else if (sync_rise) begin
      loss_cnt_reg <= 8'h00;
      ext_reg      <= 1'h1;
    end else if (loss_cnt_reg == 8'(`DVS_SYNC_LOSS_CYC)) begin
      ext_reg      <= 1'h0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 8'h01;
    end
  end

  // a static sync pin picks the output mode, a toggling one the slave mode unless ctrl bit 1 forces the internal osc
  always_comb begin
    if (ext_reg & ~ctrl_reg[`DVS_CTRL_INT_BIT]) begin
      mode = dvs_pkg::DVS_CK_SLAVE;
    end else if (i_sync & ~ext_reg) begin
      mode = dvs_pkg::DVS_CK_QUAD;
    end else begin
      mode = dvs_pkg::DVS_CK_INPHASE;
    end
  end

  // divider source: sync edges in slave mode, oscillator edges otherwise
  assign src_rise = (mode == dvs_pkg::DVS_CK_SLAVE) ? sync_rise
                                                    : osc_rise;

  //----------------------------------------------------------
  // divide by two and phase clock
  //----------------------------------------------------------
  // the divider keeps toggling through a source change, so the
  // switching rate only glitches by one half period
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sw_clk_reg <= 1'h0;
      cyc1_reg   <= 1'h0;
      cyc2_reg   <= 1'h0;
    end else begin
      cyc1_reg <= src_rise & ~sw_clk_reg;
      cyc2_reg <= src_rise & sw_clk_reg;
      if (src_rise) begin
        sw_clk_reg <= ~sw_clk_reg;
      end
    end
  end

  // quad mode: inverted oscillator rises a quarter switching period late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ck_reg <= 1'h0;
    end else begin
      unique case (mode)
        dvs_pkg::DVS_CK_QUAD: ck_reg <= ~i_osc;
        dvs_pkg::DVS_CK_SLAVE: begin
          ck_reg <= sw_clk_reg ^ src_rise;
        end
        dvs_pkg::DVS_CK_INPHASE: begin
          ck_reg <= sw_clk_reg ^ src_rise;
        end
      endcase
    end
  end

  //----------------------------------------------------------
  // soft-start / soft-stop sequencer
  //----------------------------------------------------------
  // one shared ramp keeps the two channels in lockstep
  always_ff @(posedge i_clk) begin
    if (i_rst | fault) begin
      state_reg    <= dvs_pkg::DVS_OFF;
      dac_reg      <= `DVS_DAC_ZERO;
      step_cnt_reg <= 4'h0;
      en_d_reg     <= 1'h0;
    end else begin
      en_d_reg <= enable;
      unique case (state_reg)
        dvs_pkg::DVS_OFF: begin
          step_cnt_reg <= 4'h0;
          if (enable) begin
            state_reg <= dvs_pkg::DVS_RAMP_UP;
          end
        end
        dvs_pkg::DVS_RAMP_UP: begin
          if (~enable & en_d_reg) begin
            state_reg <= dvs_pkg::DVS_RAMP_DOWN;
          end else if (dac_reg == `DVS_DAC_TOP) begin
            state_reg <= dvs_pkg::DVS_ON;
          end else if (cyc1_reg) begin
            step_cnt_reg <= step_cnt_reg + 4'h1;
            if (step_cnt_reg == `DVS_STEP_CYC) begin
              dac_reg <= dac_reg + 7'h01;
            end
          end
        end
        dvs_pkg::DVS_ON: begin
          if (~enable) begin
            state_reg    <= dvs_pkg::DVS_RAMP_DOWN;
            step_cnt_reg <= 4'h0;
          end
        end
        dvs_pkg::DVS_RAMP_DOWN: begin
          if (enable & ~en_d_reg) begin
            state_reg <= dvs_pkg::DVS_RAMP_UP;   // re-enable climbs from here
          end else if (dac_reg == `DVS_DAC_ZERO) begin
            state_reg <= dvs_pkg::DVS_OFF;
          end else if (cyc1_reg) begin
            step_cnt_reg <= step_cnt_reg + 4'h1;
            if (step_cnt_reg == `DVS_STEP_CYC) begin
              dac_reg <= dac_reg - 7'h01;
            end
          end
        end
      endcase
    end
  end

  assign run = (state_reg != dvs_pkg::DVS_OFF);

  //----------------------------------------------------------
  // gate drivers, one per channel
  //----------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic       hs_req_reg;   // on-time request from cycle start to pwm end
      logic [1:0] dead_reg;     // cycles the high side has been off
      logic       start;
      assign start = (ch == 0) ? cyc1_reg : cyc2_reg;

      // request window; pwm end from the analog comparator closes it
      always_ff @(posedge i_clk) begin
        if (i_rst | fault | ~run) begin
          hs_req_reg <= 1'h0;
        end else if (start) begin
          hs_req_reg <= 1'h1;
        end else if (i_pwm_end[ch]) begin
          hs_req_reg <= 1'h0;
        end
      end

      // high side waits for low side off; low side waits out dead time
      always_ff @(posedge i_clk) begin
        if (i_rst | fault | ~run) begin
          o_gate[ch] <= '0;
          dead_reg   <= 2'h0;
        end else begin
          o_gate[ch].hs <= hs_req_reg & ~o_gate[ch].ls;
          if (o_gate[ch].hs | hs_req_reg) begin
            dead_reg      <= 2'h0;
            o_gate[ch].ls <= 1'h0;
          end else if (dead_reg < 2'(`DVS_DEAD_CYC)) begin
            dead_reg <= dead_reg + 2'h1;
          end else begin
            o_gate[ch].ls <= 1'h1;
          end
        end
      end
    end
  endgenerate

  //----------------------------------------------------------
  // shutdown parking and power-good
  //----------------------------------------------------------
  // gates are parked whenever the ramp is off, whatever the cause
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_high_side_to_switch_node <= 1'h1;
      o_comp_discharge           <= 1'h1;
      pg_reg                     <= 1'h0;
    end else begin
      o_high_side_to_switch_node <= ~run | fault;
      o_comp_discharge           <= ~run | fault;
      // any low comparator or fault pulls low; release needs ramp done
      pg_reg <= ~fault & ~(|und_reg)
              & (state_reg == dvs_pkg::DVS_ON);
    end
  end

  // open drain: the data line is always low, only the enable moves
  assign o_power_good_rst_n_out = 1'h0;
  assign o_power_good_rst_n_oe  = ~pg_reg;
  assign o_dac_code             = dac_reg;
  assign o_ramp_done            = (state_reg == dvs_pkg::DVS_ON);
  assign o_phase_clock_out      = ck_reg;

  //----------------------------------------------------------
  // avalon-mm register slave
  //----------------------------------------------------------
  assign req      = i_avs_read | i_avs_write;
  assign sel_ctrl = (i_avs_address == `DVS_OFS_CTRL);
  assign sel_stat = (i_avs_address == `DVS_OFS_STATUS);

  always_comb begin
    status.supply_low_lockout      = i_supply_low_lockout;
    status.hot       = hot_reg;
    status.pgood     = pg_reg;
    status.ext_sync  = (mode == dvs_pkg::DVS_CK_SLAVE);
    status.ramp_done = (state_reg == dvs_pkg::DVS_ON);
    status.state     = state_reg;
    status.dac       = dac_reg;
  end

  // every access waits exactly one cycle; the answer comes at the second edge
  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;

  // answer phase and read data capture; unmapped reads return zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_reg   <= 1'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (i_avs_read & ~ack_reg) begin
        if (sel_ctrl) begin
          rdata_reg <= {30'h0, ctrl_reg};
        end else if (sel_stat) begin
          rdata_reg <= {18'h0_0000, status};
        end else begin
          rdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // control register write; only byte lane 0 holds bits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= `DVS_CTRL_RESET;
    end else if (i_avs_write & ack_reg & sel_ctrl & i_avs_byteenable[0]) begin
      ctrl_reg <= i_avs_writedata[1:0];
    end
  end

endmodule
`default_nettype wire

// >>> dvs_checker.sv
// assertion checker bound to the sequencer ports
`default_nettype none
module dvs_checker (
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic [1:0]               i_under90,
  input wire logic                     i_thermal,
  input wire logic                     i_supply_low_lockout,
  input wire dvs_pkg::dvs_gate_t [1:0] o_gate,
  input wire logic                     o_high_side_to_switch_node,
  input wire logic [6:0]               o_dac_code,
  input wire logic                     o_ramp_done,
  input wire logic                     o_power_good_rst_n_out,
  input wire logic                     o_power_good_rst_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  //----------------------------------------
  // one clock domain, reset disables all
  //----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_gate_no_overlap: assert property (
    !(o_gate[0].hs && o_gate[0].ls) && !(o_gate[1].hs && o_gate[1].ls))
    else $error("gate pair both on");
  a_pg_open_drain: assert property (
    o_power_good_rst_n_out == 1'b0) else $error("power good driven high");
  a_lockout_stops_all: assert property (
    i_supply_low_lockout |=> o_gate == 4'h0 && o_power_good_rst_n_oe)
    else $error("lockout left gates or reset");
  a_dac_in_range: assert property (
    o_dac_code <= 7'h40) else $error("dac above top");
  a_dac_one_step: assert property (
    o_dac_code != $past(o_dac_code) |-> o_dac_code == $past(o_dac_code) + 7'h01
    || o_dac_code == $past(o_dac_code) - 7'h01 || o_dac_code == 7'h00)
    else $error("dac jumped");
  a_done_at_top: assert property (
    o_ramp_done |-> o_dac_code == 7'h40) else $error("done before top");
  a_release_needs_done: assert property (
    !o_power_good_rst_n_oe |-> $past(o_ramp_done)) else $error("early release");
  a_under_pulls_low: assert property (
    (|i_under90) [*4] |=> o_power_good_rst_n_oe) else $error("low output not flagged");
  a_thermal_stops: assert property (
    i_thermal [*4] |=> o_gate == 4'h0 && o_dac_code == 7'h00 && o_power_good_rst_n_oe)
    else $error("thermal left running");
  a_parked_gates_low: assert property (
    o_high_side_to_switch_node |-> o_gate == 4'h0) else $error("parked but gate on");
endmodule
bind dvs_sequencer dvs_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_under90(i_under90), .i_thermal(i_thermal),
  .i_supply_low_lockout(i_supply_low_lockout), .o_gate(o_gate),
  .o_high_side_to_switch_node(o_high_side_to_switch_node), .o_dac_code(o_dac_code),
  .o_ramp_done(o_ramp_done), .o_power_good_rst_n_out(o_power_good_rst_n_out),
  .o_power_good_rst_n_oe(o_power_good_rst_n_oe));
`default_nettype wire

// >>> dvs_stage_model.sv
// behavioural power stage: pwm comparators and output-low comparators
`default_nettype none
module dvs_stage_model (
  input  wire logic                     i_clk,
  input  wire dvs_pkg::dvs_gate_t [1:0] i_gate,
  input  wire logic [6:0]               i_dac_code,
  input  wire logic [1:0]               i_sag,
  output var  logic [1:0]               o_under90,
  output var  logic [1:0]               o_pwm_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] on_cnt [2]; // on-time length per channel, settles while gates are held off
  // output tracks the reference: below 58/64 reads as under 90%; sag forces a dip
  always @(posedge i_clk) begin
    for (int k = 0; k < 2; k++) begin
      on_cnt[k] <= i_gate[k].hs ? on_cnt[k] + 2'h1 : 2'h0;
      o_pwm_end[k] <= i_gate[k].hs && on_cnt[k] == 2'h2;
    end
    o_under90 <= {2{i_dac_code < 7'h3A}} | i_sag;
  end
endmodule
`default_nettype wire

// >>> tb_dvs_sequencer.sv
// self-checking testbench for the dual regulator sequencer
`default_nettype none
module tb_dvs_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst = 1, en = 0, osc = 0, sync = 0, hot = 0, low = 0, ph_d = 0;
  logic rd = 0, wr = 0;
  logic [1:0] sag = 2'h0, sync_mode = 2'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q;
  dvs_pkg::dvs_gate_t [1:0] gate;
  logic park, dis, done, ph, pg_o, pg_oe, wreq;
  logic [6:0] dac;
  logic [31:0] rdat;
  logic [1:0] u90, pend;
  int n_mismatch = 0, n_checks = 0, n_ph = 0, ocnt = 0, t;
  int t_ph = 0, t_hs0 = 0, t_hs1 = 0; // clock counts at the last phase clock and high-gate rises
  logic [1:0] hs_d = 2'h0;
  dvs_sequencer DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_enable(en), .i_sync(sync), .i_osc(osc),
    .i_under90(u90), .i_thermal(hot), .i_supply_low_lockout(low), .i_pwm_end(pend),
    .o_gate(gate), .o_high_side_to_switch_node(park), .o_comp_discharge(dis),
    .o_dac_code(dac), .o_ramp_done(done), .o_phase_clock_out(ph),
    .o_power_good_rst_n_out(pg_o), .o_power_good_rst_n_oe(pg_oe),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq));
  dvs_stage_model u_stage (
    .i_clk(i_clk), .i_gate(gate), .i_dac_code(dac), .i_sag(sag),
    .o_under90(u90), .o_pwm_end(pend));
  //----------------------------------------
  // clocks: 10 MHz, oscillator at 8 cycles, sync twice its rate
  //----------------------------------------
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    ocnt <= ocnt + 1;
    osc <= ocnt[2];
    sync <= (sync_mode == 2'h2) ? ocnt[1] : sync_mode[0];
    ph_d <= ph;
    if (ph && !ph_d) n_ph <= n_ph + 1;
    if (ph && !ph_d) t_ph <= ocnt;
    hs_d <= {gate[1].hs, gate[0].hs};
    if (gate[0].hs && !hs_d[0]) t_hs0 <= ocnt;
    if (gate[1].hs && !hs_d[1]) t_hs1 <= ocnt;
  end
  //----------------------------------------
  // tasks
  //----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access; the request stands until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge i_clk);
    while (wreq !== 1'b0) @(posedge i_clk);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // phase clock rising edges in 800 cycles after mode settles
  task automatic rate(input logic [1:0] m, input int exp);
    int c;
    sync_mode <= m;
    repeat (300) @(posedge i_clk);
    c = n_ph;
    repeat (800) @(posedge i_clk);
    check(32'(n_ph - c >= exp - 2 && n_ph - c <= exp + 2), 32'h1);
  endtask
  task automatic wait_ramp(input logic top);
    t = 0;
    while ((top ? done : park) !== 1'b1 && t < 20000) begin
      @(posedge i_clk);
      t++;
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard, about twice the expected run
  initial begin
    repeat (80000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    check(32'(gate), 32'h0);
    check(32'({park, dis, pg_oe}), 32'h7);
    check(32'(pg_o), 32'h0);
    check(32'(dac), 32'h0);
    bus(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h1);
    bus(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, 4'h4, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h4, 32'h0, q);
    check(32'(q[9:0]), 32'h0);
    rate(2'h0, 50);
    rate(2'h1, 100);
    rate(2'h2, 100);
    bus(1'b0, 4'h4, 32'h0, q);
    check(32'(q[10]), 32'h1);
    bus(1'b1, 4'h0, 32'h3, q);
    rate(2'h2, 50);
    bus(1'b1, 4'h0, 32'h1, q);
    rate(2'h0, 50);
    bus(1'b0, 4'h4, 32'h0, q);
    check(32'(q[10]), 32'h0);
    // soft-start: 64 steps of 16 cycles of 16 clocks
    en <= 1'b1;
    wait_ramp(1'b1);
    check(32'(t > 16300 && t < 16450), 32'h1);
    check(32'(dac), 32'h40);
    check(32'({park, dis}), 32'h0);
    repeat (6) @(posedge i_clk);
    check(32'(pg_oe), 32'h0);
    check(32'(t_hs1 - t_hs0 == 8 || t_hs0 - t_hs1 == 8), 32'h1);
    check(32'((t_hs0 - t_ph + 16) % 16 < 8), 32'h1);
    bus(1'b0, 4'h4, 32'h0, q);
    check(32'(q[9:7]), 32'h6);
    sag <= 2'h2;
    repeat (6) @(posedge i_clk);
    check(32'(pg_oe), 32'h1);
    sag <= 2'h0;
    repeat (6) @(posedge i_clk);
    check(32'(pg_oe), 32'h0);
    // soft-stop runs the ramp back before shutdown
    en <= 1'b0;
    repeat (20) @(posedge i_clk);
    check(32'({done, dis, park}), 32'h0);
    wait_ramp(1'b0);
    check(32'(t > 16250 && t < 16450), 32'h1);
    check(32'(dac), 32'h0);
    // thermal overload mid-ramp, then recovery
    en <= 1'b1;
    repeat (3000) @(posedge i_clk);
    check(32'(dac > 7'h05), 32'h1);
    hot <= 1'b1;
    repeat (6) @(posedge i_clk);
    check(32'({gate, dac, pg_oe}), 32'h1);
    hot <= 1'b0;
    repeat (30) @(posedge i_clk);
    check(32'(dis), 32'h0);
    low <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(32'({gate, dac, pg_oe}), 32'h1);
    low <= 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
